// ---- itm_pkg.sv ----
// constants and types for the instruction timing model
package itm_pkg;
    // clock period and time units in nanoseconds
    localparam int CLK_NS = 8;
    typedef logic [15:0] itm_ns_t;
    typedef logic [3:0]  itm_cyc_t;

    // instruction classes
    typedef enum logic [3:0] {
        ITM_ARITH   = 4'h0,  // add sub cmp bit bic bis xor
        ITM_COPY    = 4'h1,  // copy_operand
        ITM_SINGLE  = 4'h2,  // clear etc, rotate left, byte_swap
        ITM_SHR     = 4'h3,  // rotate_right_op, arith_right_shift
        ITM_SXT     = 4'h4,  // sign_extend
        ITM_PREV    = 4'h5,  // move_from/to_prev_space
        ITM_BRANCH  = 4'h6,
        ITM_LOOP    = 4'h7,  // loop_decrement_branch
        ITM_CTRL    = 4'h8,  // fixed-time control and trap group
        ITM_EXTINT  = 4'h9,  // extended_integer_option
        ITM_FLOAT   = 4'hA
    } itm_class_e;

    // operand specifier field layout
    localparam int SPEC_W    = 6;
    localparam int MODE_LSB  = 3;
    localparam int MODE_W    = 3;

    // address time per mode, ns
    localparam itm_ns_t ADR_NS [8] = '{16'd0, 16'd780, 16'd840, 16'd1740,
                                       16'd840, 16'd1740, 16'd1460, 16'd2360};
    localparam itm_ns_t DST_HI_NS [8] = '{16'd0, 16'd900, 16'd900, 16'd1800,
                                          16'd900, 16'd1800, 16'd1740, 16'd2640};
    localparam itm_cyc_t SRC_CYC [8] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h1, 4'h2, 4'h2, 4'h3};
    localparam itm_cyc_t DST_CYC [8] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h1, 4'h2, 4'h2, 4'h1};
    localparam itm_ns_t ODD_ADR_NS  = 16'd340;
    localparam itm_ns_t ODD_EF_NS   = 16'd480;
    localparam itm_ns_t BYTE_SHR_NS = 16'd140;

    localparam itm_ns_t EF_RR_NS    = 16'd990;
    localparam itm_ns_t EF_MR_NS    = 16'd1600;
    localparam itm_ns_t EF_SHR_NS   = 16'd1250;
    localparam itm_ns_t EF_SXT_NS   = 16'd900;
    localparam itm_cyc_t EF_BASIC_CYC = 4'h1;

    // copy execute/fetch, index by destination mode; dst 6/7 with src 0 use separate word and byte constants
    localparam itm_ns_t COPY_W_NS [8] = '{16'd1460, 16'd2420, 16'd2420, 16'd3180,
                                          16'd2420, 16'd3180, 16'd3180, 16'd4020};
    localparam itm_ns_t COPY_B_NS [8] = '{16'd1800, 16'd2560, 16'd2560, 16'd3320,
                                          16'd2560, 16'd3320, 16'd3320, 16'd4160};
    localparam itm_cyc_t COPY_CYC [8] = '{4'h0, 4'h2, 4'h2, 4'h3, 4'h2, 4'h3, 4'h3, 4'h4};
    localparam itm_ns_t COPY_RR_W_NS  = 16'd900;
    localparam itm_ns_t COPY_RR_B_NS  = 16'd1800;
    localparam itm_ns_t COPY_6R_W_NS  = 16'd2840;
    localparam itm_ns_t COPY_6R_B_NS  = 16'd2980;
    localparam itm_ns_t COPY_7R_W_NS  = 16'd3680;
    localparam itm_ns_t COPY_7R_B_NS  = 16'd3820;

    localparam itm_ns_t PREV_FROM_NS  = 16'd3740;
    localparam itm_ns_t PREV_TO_NS    = 16'd3680;
    localparam itm_cyc_t PREV_CYC     = 4'h2;

    localparam itm_ns_t BR_TAKEN_NS   = 16'd1760;
    localparam itm_ns_t BR_NOT_NS     = 16'd1400;
    localparam itm_ns_t LOOP_TAKEN_NS = 16'd2360;
    localparam itm_ns_t LOOP_NOT_NS   = 16'd2040;

    // control group selector codes
    localparam logic [2:0] CT_HALT = 3'h0, CT_RET = 3'h1, CT_MARK = 3'h2, CT_IRET = 3'h3,
                           CT_SETCC = 3'h4, CT_CLRCC = 3'h5, CT_WAIT = 3'h6, CT_TRAP = 3'h7;
    localparam itm_ns_t CTRL_NS [8] = '{16'd2420, 16'd2420, 16'd2560, 16'd2920,
                                        16'd1720, 16'd2020, 16'd2240, 16'd5800};
    localparam itm_cyc_t CTRL_CYC [8] = '{4'h1, 4'h2, 4'h2, 4'h3, 4'h1, 4'h1, 4'h1, 4'h5};
    localparam itm_ns_t HALT_POLL_NS  = 16'd440;
    localparam itm_ns_t WAIT_POLL_NS  = 16'd1120;

    // extended integer
    localparam itm_ns_t EI_SRC_NS [8] = '{16'd280, 16'd780, 16'd980, 16'd1740,
                                          16'd980, 16'd1740, 16'd1740, 16'd2640};
    localparam logic [2:0] EI_MUL = 3'h0, EI_DIV = 3'h1, EI_SHR = 3'h2, EI_SHL = 3'h3,
                           EI_DBL0 = 3'h4, EI_DBL = 3'h5;
    localparam itm_ns_t EI_EF_NS [6] = '{16'd8880, 16'd11300, 16'd2580, 16'd2780,
                                         16'd2780, 16'd3260};
    localparam itm_ns_t EI_SHIFT_NS   = 16'd300;

    // floating point
    localparam logic [1:0] FP_SUM = 2'h0, FP_DIFF = 2'h1, FP_PROD = 2'h2, FP_QUOT = 2'h3;
    localparam itm_ns_t FP_BASE_NS [4] = '{16'd18780, 16'd19080, 16'd29000, 16'd46720};
    localparam itm_ns_t FP_ALIGN_NS   = 16'd300;
    localparam itm_ns_t FP_NORM_NS    = 16'd340;
    localparam logic [4:0] FP_ALIGN_MAX = 5'd23;
    localparam logic [4:0] FP_NORM_MAX  = 5'd25;
    localparam itm_ns_t FP_IRQ_MAX_NS = 16'd20080;
    localparam itm_ns_t FP_NEAR_NS    = 16'd2000;

    // per memory cycle penalties
    localparam itm_ns_t MMU_CYC_NS    = 16'd150;
    localparam itm_ns_t BUS_SYNC_NS   = 16'd80;

    // latency limits
    localparam itm_ns_t SERVICE_NS    = 16'd5420;
    localparam itm_ns_t DMA_NS        = 16'd3500;
    localparam int SERVICE_CYC = SERVICE_NS / CLK_NS;
    localparam int DMA_CYC     = DMA_NS / CLK_NS;
    localparam int BUS_RESET_MS = 80;
    localparam int BUS_RESET_CYC = BUS_RESET_MS * 1000000 / CLK_NS;
endpackage : itm_pkg

// ---- itm_calc.sv ----
// combinational instruction time and memory cycle calculator
module itm_calc (
    input  wire logic [3:0]  iclass,
    input  wire logic [5:0]  src_spec,
    input  wire logic [5:0]  dst_spec,
    input  wire logic        byte_op,
    input  wire logic        odd_byte,
    input  wire logic        hi_dst,
    input  wire logic [2:0]  sub_op,
    input  wire logic        taken,
    input  wire logic [4:0]  shifts_a,
    input  wire logic [4:0]  shifts_n,
    input  wire logic        mmu_fitted,
    input  wire logic        bus_sync,
    output logic      [15:0] time_ns,
    output logic      [3:0]  mem_cyc,
    output logic             illegal
);
    logic [2:0]  sm, dm;
    logic [15:0] src_t, dst_t, ef_t, base_t, pen_t;
    logic [3:0]  src_c, dst_c, ef_c;
    logic [4:0]  sa, sn;

    assign sm = src_spec[itm_pkg::MODE_LSB +: itm_pkg::MODE_W];
    assign dm = dst_spec[itm_pkg::MODE_LSB +: itm_pkg::MODE_W];
    assign sa = (shifts_a > itm_pkg::FP_ALIGN_MAX) ? itm_pkg::FP_ALIGN_MAX : shifts_a;
    assign sn = (shifts_n > itm_pkg::FP_NORM_MAX) ? itm_pkg::FP_NORM_MAX : shifts_n;

    assign src_t = itm_pkg::ADR_NS[sm] + ((odd_byte && sm != 3'h0) ? itm_pkg::ODD_ADR_NS : 16'h0000);
    assign src_c = itm_pkg::SRC_CYC[sm];
    assign dst_t = (hi_dst && sm == 3'h0 ? itm_pkg::DST_HI_NS[dm] : itm_pkg::ADR_NS[dm])
                 + ((odd_byte && dm != 3'h0) ? itm_pkg::ODD_ADR_NS : 16'h0000);
    assign dst_c = itm_pkg::DST_CYC[dm];

    always_comb begin
        ef_t    = 16'h0000;
        ef_c    = 4'h0;
        base_t  = 16'h0000;
        illegal = 1'b0;
        case (iclass)
            4'h0: begin
                ef_t   = (sm == 3'h0 && dm == 3'h0) ? itm_pkg::EF_RR_NS : itm_pkg::EF_MR_NS;
                ef_t   = ef_t + ((odd_byte && dm != 3'h0) ? itm_pkg::ODD_EF_NS : 16'h0000);
                ef_c   = itm_pkg::EF_BASIC_CYC;
                base_t = src_t + dst_t;
                ef_c   = ef_c + src_c + dst_c;
            end
            4'h1: begin
                if (dm == 3'h0 && sm == 3'h0)
                    ef_t = byte_op ? itm_pkg::COPY_RR_B_NS : itm_pkg::COPY_RR_W_NS;
                else if (dm == 3'h6 && sm == 3'h0)
                    ef_t = byte_op ? itm_pkg::COPY_6R_B_NS : itm_pkg::COPY_6R_W_NS;
                else if (dm == 3'h7 && sm == 3'h0)
                    ef_t = byte_op ? itm_pkg::COPY_7R_B_NS : itm_pkg::COPY_7R_W_NS;
                else
                    ef_t = byte_op ? itm_pkg::COPY_B_NS[dm] : itm_pkg::COPY_W_NS[dm];
                ef_c   = itm_pkg::COPY_CYC[dm] + src_c;
                base_t = src_t;
            end
            4'h2, 4'h3, 4'h4: begin
                ef_t = (iclass == 4'h3) ? itm_pkg::EF_SHR_NS :
                       (iclass == 4'h4) ? itm_pkg::EF_SXT_NS : itm_pkg::EF_RR_NS;
                if (dm != 3'h0)
                    ef_t = ef_t + itm_pkg::EF_MR_NS - itm_pkg::EF_RR_NS
                         + (odd_byte ? itm_pkg::ODD_EF_NS : 16'h0000);
                if (iclass == 4'h3 && byte_op)
                    ef_t = ef_t + itm_pkg::BYTE_SHR_NS;
                ef_c   = itm_pkg::EF_BASIC_CYC + dst_c;
                base_t = dst_t;
            end
            4'h5: begin
                illegal = !mmu_fitted;
                ef_t    = sub_op[0] ? itm_pkg::PREV_TO_NS : itm_pkg::PREV_FROM_NS;
                ef_c    = itm_pkg::PREV_CYC;
            end
            4'h6: begin
                ef_t = taken ? itm_pkg::BR_TAKEN_NS : itm_pkg::BR_NOT_NS;
                ef_c = itm_pkg::EF_BASIC_CYC;
            end
            4'h7: begin
                ef_t = taken ? itm_pkg::LOOP_TAKEN_NS : itm_pkg::LOOP_NOT_NS;
                ef_c = itm_pkg::EF_BASIC_CYC;
            end
            4'h8: begin
                ef_t = itm_pkg::CTRL_NS[sub_op];
                ef_c = itm_pkg::CTRL_CYC[sub_op];
            end
            4'h9: begin
                illegal = sub_op > itm_pkg::EI_DBL;
                ef_t    = illegal ? 16'h0000 : itm_pkg::EI_EF_NS[sub_op];
                if (sub_op == itm_pkg::EI_SHR || sub_op == itm_pkg::EI_SHL || sub_op == itm_pkg::EI_DBL)
                    ef_t = ef_t + 16'(itm_pkg::EI_SHIFT_NS * shifts_a);
                base_t = itm_pkg::EI_SRC_NS[sm];
                ef_c   = src_c;
            end
            4'hA: begin
                ef_t = itm_pkg::FP_BASE_NS[sub_op[1:0]];
                if (sub_op[1] == 1'b0)
                    ef_t = ef_t + 16'(itm_pkg::FP_ALIGN_NS * sa);
                if (sub_op[1:0] != itm_pkg::FP_PROD)
                    ef_t = ef_t + 16'(itm_pkg::FP_NORM_NS * sn);
            end
            default: illegal = 1'b1;
        endcase
    end

    // per memory cycle penalties on total cycle count
    assign pen_t = 16'((mmu_fitted ? itm_pkg::MMU_CYC_NS : 16'h0000) * ef_c)
                 + 16'((bus_sync ? itm_pkg::BUS_SYNC_NS : 16'h0000) * ef_c);
    assign time_ns = base_t + ef_t + pen_t;
    assign mem_cyc = ef_c;
endmodule : itm_calc

// ---- itm_timer.sv ----
// instruction timing model: per-instruction timer with interrupt and dma handover
// Notes on behaviour
// - two-operand = src+dst+ef; copy drops dst; single = dst+ef; extended integer src+ef; others ef only
// - source address time per mode, odd bytes add 0.34 us
// - destination time per mode, higher values for arith with source mode 0
// - arith execute/fetch 0.99 or 1.60 us, odd memory byte adds 0.48
// - copy execute/fetch depends on modes, word and byte tables
// - single operand 0.99, right shifts 1.25, sign extend 0.90
// - byte right rotate and shift add 0.14 us
// - previous-space moves need memory management, 3.74 and 3.68 us
// - branch 1.76 taken 1.40 not; loop branch 2.36 and 2.04
// - halt 2.42 then polls console every 0.44 us; other fixed times
// - wait 2.24 then polls interrupt every 1.12 us; traps 5.80
// - memory management adds 0.15 us per memory cycle
// - standard bus sync adds 0.08 us per memory cycle
// - interrupts acknowledged only at instruction end, except floating point
// - acknowledge to service routine start at most 5.42 us
// - dma grant within 3.50 us of request
// - extended integer time is source plus execute
// - extended integer execute times with 0.30 us per shift
// - floating shift costs 0.30 align up to 23, 0.34 normalise up to 25
// - floating basic times 18.78, 19.08, 29.00, 46.72 us
// - floating op aborted by higher interrupt unless near end, 20.08 us max
// - operand specifiers are 3-bit mode plus 3-bit register
module itm_timer (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic        start,
    input  wire logic [3:0]  iclass,
    input  wire logic [5:0]  src_spec,
    input  wire logic [5:0]  dst_spec,
    input  wire logic        byte_op,
    input  wire logic        odd_byte,
    input  wire logic        hi_dst,
    input  wire logic [2:0]  sub_op,
    input  wire logic        taken,
    input  wire logic [4:0]  shifts_a,
    input  wire logic [4:0]  shifts_n,
    input  wire logic        mmu_fitted,
    input  wire logic        bus_sync,
    input  wire logic        irq_pin,
    input  wire logic        irq_higher,
    input  wire logic        console_pin,
    input  wire logic        dma_pin,
    output logic             busy_ff,
    output logic             done_ff,
    output logic             illegal_ff,
    output logic      [3:0]  mem_cyc_ff,
    output logic             irq_ack_ff,
    output logic             service_ff,
    output logic             dma_grant_ff,
    output logic             abort_ff,
    output logic             console_ff
);
    typedef enum logic [4:0] {
        ITM_IDLE = 5'b00001,
        ITM_RUN  = 5'b00010,
        ITM_POLL = 5'b00100,
        ITM_SVC  = 5'b01000,
        ITM_HOLD = 5'b10000
    } itm_state_e;

    localparam logic [15:0] HALT_POLL_CYC = 16'(itm_pkg::HALT_POLL_NS / itm_pkg::CLK_NS);
    localparam logic [15:0] WAIT_POLL_CYC = 16'(itm_pkg::WAIT_POLL_NS / itm_pkg::CLK_NS);
    localparam logic [15:0] SVC_CYC       = 16'(itm_pkg::SERVICE_CYC);
    localparam logic [15:0] DMA_CYC       = 16'(itm_pkg::DMA_CYC);
    localparam logic [15:0] NEAR_CYC      = 16'(itm_pkg::FP_NEAR_NS / itm_pkg::CLK_NS);

    itm_state_e  state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] dma_cnt_ff;
    logic [1:0]  irq_s_ff, con_s_ff, dma_s_ff;
    logic        is_halt_ff, is_float_ff, wait_ff;
    logic [15:0] calc_ns;
    logic [3:0]  calc_cyc;
    logic        calc_ill;
    logic [15:0] calc_cnt;
    logic        irq_now, con_now, dma_now, cnt_zero, fp_abort, poll_tick;

    itm_calc u_calc (
        .iclass     (iclass),
        .src_spec   (src_spec),
        .dst_spec   (dst_spec),
        .byte_op    (byte_op),
        .odd_byte   (odd_byte),
        .hi_dst     (hi_dst),
        .sub_op     (sub_op),
        .taken      (taken),
        .shifts_a   (shifts_a),
        .shifts_n   (shifts_n),
        .mmu_fitted (mmu_fitted),
        .bus_sync   (bus_sync),
        .time_ns    (calc_ns),
        .mem_cyc    (calc_cyc),
        .illegal    (calc_ill)
    );

    // pins pass two flops before use; only bit 1 is read
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_s_ff <= 2'h0;
            con_s_ff <= 2'h0;
            dma_s_ff <= 2'h0;
        end else begin
            irq_s_ff <= {irq_s_ff[0], irq_pin};
            con_s_ff <= {con_s_ff[0], console_pin};
            dma_s_ff <= {dma_s_ff[0], dma_pin};
        end
    end

    assign irq_now   = irq_s_ff[1];
    assign con_now   = con_s_ff[1];
    assign dma_now   = dma_s_ff[1];
    // round down: instruction time is a typical figure, never less than one cycle
    assign calc_cnt  = (calc_ns < 16'(itm_pkg::CLK_NS)) ? 16'h0001 : 16'(calc_ns / itm_pkg::CLK_NS);
    assign cnt_zero  = cnt_ff == 16'h0000;
    assign poll_tick = cnt_zero;
    // abort unless near completion
    // float flag outlives the run; gate by state or service would re-abort
    assign fp_abort  = state_ff == ITM_RUN && is_float_ff && irq_now && irq_higher && cnt_ff > NEAR_CYC;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ITM_IDLE: begin
                if (irq_now) begin
                    nxt_state = ITM_SVC;
                    nxt_cnt   = SVC_CYC - 16'h0001;
                end else if (start && !calc_ill) begin
                    nxt_state = ITM_RUN;
                    nxt_cnt   = calc_cnt - 16'h0001;
                end
            end
            ITM_RUN: begin
                if (fp_abort) begin
                    nxt_state = ITM_SVC;
                    nxt_cnt   = SVC_CYC - 16'h0001;
                end else if (!cnt_zero)
                    nxt_cnt = cnt_ff - 16'h0001;
                else if (is_halt_ff) begin
                    nxt_state = ITM_HOLD;
                    nxt_cnt   = HALT_POLL_CYC - 16'h0001;
                end else if (mem_cyc_ff == 4'h1 && state_ff == ITM_RUN && wait_ff) begin
                    nxt_state = ITM_POLL;
                    nxt_cnt   = WAIT_POLL_CYC - 16'h0001;
                end else
                    nxt_state = ITM_IDLE;
            end
            ITM_POLL: begin
                if (!cnt_zero)
                    nxt_cnt = cnt_ff - 16'h0001;
                else if (irq_now)
                    nxt_state = ITM_IDLE;
                else
                    nxt_cnt = WAIT_POLL_CYC - 16'h0001;
            end
            ITM_SVC: begin
                if (!cnt_zero)
                    nxt_cnt = cnt_ff - 16'h0001;
                else
                    nxt_state = ITM_IDLE;
            end
            ITM_HOLD: begin
                if (!cnt_zero)
                    nxt_cnt = cnt_ff - 16'h0001;
                else if (con_now)
                    nxt_state = ITM_IDLE;
                else
                    nxt_cnt = HALT_POLL_CYC - 16'h0001;
            end
            default: begin
                nxt_state = ITM_IDLE;
                nxt_cnt   = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff    <= ITM_IDLE;
            cnt_ff      <= 16'h0000;
            is_halt_ff  <= 1'b0;
            is_float_ff <= 1'b0;
            wait_ff     <= 1'b0;
            mem_cyc_ff  <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            if (state_ff == ITM_IDLE && nxt_state == ITM_RUN) begin
                is_halt_ff  <= iclass == 4'h8 && sub_op == itm_pkg::CT_HALT;
                wait_ff     <= iclass == 4'h8 && sub_op == itm_pkg::CT_WAIT;
                is_float_ff <= iclass == 4'hA;
                mem_cyc_ff  <= calc_cyc;
            end
        end
    end

    // dma grant counter, bus handed over before limit
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            dma_cnt_ff   <= 16'h0000;
            dma_grant_ff <= 1'b0;
        end else begin
            dma_cnt_ff   <= dma_now && !dma_grant_ff ? dma_cnt_ff + 16'h0001 : 16'h0000;
            dma_grant_ff <= dma_now && (dma_grant_ff || dma_cnt_ff >= DMA_CYC - 16'h0002
                            || state_ff != ITM_RUN);
        end
    end

    // status outputs
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
            illegal_ff <= 1'b0;
            irq_ack_ff <= 1'b0;
            service_ff <= 1'b0;
            abort_ff   <= 1'b0;
            console_ff <= 1'b0;
        end else begin
            busy_ff    <= nxt_state != ITM_IDLE;
            // acknowledge only from idle or floating abort
            irq_ack_ff <= (state_ff == ITM_IDLE && irq_now) || fp_abort;
            done_ff    <= state_ff == ITM_RUN && nxt_state != ITM_RUN && !fp_abort;
            illegal_ff <= state_ff == ITM_IDLE && start && calc_ill && !irq_now;
            service_ff <= state_ff == ITM_SVC && cnt_zero;
            abort_ff   <= fp_abort;
            console_ff <= state_ff == ITM_HOLD;
        end
    end

    service_time_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(irq_ack_ff) |-> ##[1:700] service_ff)
        else $error("service start late");
    ack_at_end_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_ff == ITM_RUN && !is_float_ff) |=> !irq_ack_ff)
        else $error("ack inside instruction");
    dma_grant_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $rose(dma_s_ff[1]) |-> ##[1:437] (dma_grant_ff || !dma_s_ff[1]))
        else $error("dma grant late");
    fp_abort_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        abort_ff |-> irq_ack_ff)
        else $error("abort without ack");
    branch_time_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_ff == ITM_IDLE && start && iclass == 4'h6 && taken && !mmu_fitted && !bus_sync && !irq_now)
        |=> cnt_ff == 16'd219)
        else $error("branch count wrong");
    prev_space_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_ff == ITM_IDLE && start && iclass == 4'h5 && !mmu_fitted && !irq_now) |=> illegal_ff)
        else $error("prev space accepted");
    mmu_pen_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (mmu_fitted && !bus_sync && calc_cyc != 4'h0) |-> calc_ns >= 16'(itm_pkg::MMU_CYC_NS))
        else $error("mmu penalty missing");
    wait_loop_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (state_ff == ITM_POLL && !irq_now) |=> state_ff == ITM_POLL)
        else $error("wait left early");
endmodule : itm_timer

// ---- itm_bus_dev.sv ----
// bus device model that asks for the bus by dma
module itm_bus_dev (
    input  wire logic sys_clk,
    input  wire logic dma_go,
    input  wire logic grant,
    output logic      dma_pin,
    output int        lat
);
    timeunit 1ns;
    timeprecision 1ps;
    initial dma_pin = 1'b0;
    initial lat = 0;
    always @(negedge sys_clk) begin
        if (grant) dma_pin <= 1'b0;
        else if (dma_go) dma_pin <= 1'b1;
        lat <= dma_pin ? lat + 1 : 0;
    end
endmodule : itm_bus_dev

// ---- itm_timer_bench.sv ----
// self-checking bench for the instruction timer
`define CHK(n, e, s) begin tests_run++; if ((e) !== (s)) begin err_count++; \
    $display("wrong value %s exp %0d got %0d", n, e, s); end end
module itm_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, arst_n = 0, start = 0, byte_op = 0, taken = 0, mmu_fitted = 0;
    logic bus_sync = 0, odd_byte = 0, hi_dst = 0, irq_pin = 0, irq_higher = 0, console_pin = 0;
    logic dma_go = 0, dma_pin, busy_ff, done_ff, dma_grant_ff;
    logic illegal_ff, irq_ack_ff, service_ff, abort_ff, console_ff;
    logic [3:0] iclass = 0, mem_cyc_ff;
    logic [5:0] src_spec = 0, dst_spec = 0;
    logic [2:0] sub_op = 0, m;
    logic [4:0] shifts_a = 0, shifts_n = 0;
    int lat, err_count = 0, tests_run = 0, cyc = 0, t0 = 0, q_ns[$];
    logic [3:0] q_cy[$];
    itm_timer uut (.sys_clk, .arst_n, .start, .iclass, .src_spec, .dst_spec, .byte_op, .odd_byte,
        .hi_dst, .sub_op, .taken, .shifts_a, .shifts_n, .mmu_fitted, .bus_sync, .irq_pin,
        .irq_higher, .console_pin, .dma_pin, .busy_ff, .done_ff, .illegal_ff, .mem_cyc_ff,
        .irq_ack_ff, .service_ff, .dma_grant_ff, .abort_ff, .console_ff);
    itm_bus_dev dev (.sys_clk, .dma_go, .grant(dma_grant_ff), .dma_pin, .lat);
    always #4 sys_clk = ~sys_clk;
    task give_verdict;
        if (err_count == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // penalties applied per memory cycle
    task automatic run(input logic [3:0] c, input logic [5:0] s, input logic [2:0] so,
                       input logic tk, input int ns, input logic [3:0] cy);
        int k;
        iclass = c;
        src_spec = s;
        sub_op = so;
        taken = tk;
        q_ns.push_back(ns + (mmu_fitted ? 150 : 0) * cy + (bus_sync ? 80 : 0) * cy);
        q_cy.push_back(cy);
        start = 1;
        @(negedge sys_clk) start = 0;
        k = 0;
        while (done_ff !== 1'b1 && k < 9000) begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 9000) err_count++;
        @(negedge sys_clk);
    endtask : run
    // acknowledge, then service entry in time
    task automatic serve(input logic ab);
        int n;
        n = 0;
        while (irq_ack_ff !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("irq ack", 1'b1, irq_ack_ff)
        `CHK("abort", ab, abort_ff)
        irq_pin = 0;
        n = 0;
        while (service_ff !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        `CHK("service time", 1'b1, n <= itm_pkg::SERVICE_CYC)
    endtask : serve
    always @(posedge sys_clk) begin
        cyc++;
        if (start && !busy_ff) t0 = cyc;
        if (cyc > 60000) begin
            err_count++;
            give_verdict;
        end
    end
    // 4'hF marks an unchecked memory cycle count
    always @(negedge sys_clk) if (done_ff === 1'b1) begin
        `CHK("cycles", q_ns[0] / 8 < 1 ? 1 : q_ns[0] / 8, cyc - t0)
        if (q_cy[0] != 4'hF) `CHK("mem cycles", q_cy[0], mem_cyc_ff)
        void'(q_ns.pop_front());
        void'(q_cy.pop_front());
    end
    initial begin
        void'($urandom(32'h4DB3AA0D));
        repeat (20) @(negedge sys_clk);
        arst_n = 1;
        @(negedge sys_clk);
        run(4'h0, 6'h00, 0, 0, 990, 1);
        run(4'h0, 6'h18, 0, 0, 3340, 3);
        mmu_fitted = 1;
        run(4'h0, 6'h18, 0, 0, 3340, 3);
        run(4'h5, 6'h00, 0, 0, 3740, 2);
        mmu_fitted = 0;
        bus_sync = 1;
        run(4'h0, 6'h18, 0, 0, 3340, 3);
        bus_sync = 0;
        run(4'h2, 6'h00, 0, 0, 990, 1);
        run(4'h4, 6'h00, 0, 0, 900, 1);
        byte_op = 1;
        run(4'h3, 6'h00, 0, 0, 1390, 1);
        byte_op = 0;
        run(4'h1, 6'h00, 0, 0, 900, 0);
        run(4'h6, 6'h00, 0, 1, 1760, 1);
        run(4'h6, 6'h00, 0, 0, 1400, 1);
        run(4'h7, 6'h00, 0, 1, 2360, 1);
        run(4'h7, 6'h00, 0, 0, 2040, 1);
        // control group, halt and wait loop forever
        for (int i = 1; i < 8; i++)
            if (i != 6) run(4'h8, 6'h00, 3'(i), 0, itm_pkg::CTRL_NS[i], itm_pkg::CTRL_CYC[i]);
        run(4'h9, 6'h00, 0, 0, 9160, 4'hF);
        shifts_a = 5'h2;
        shifts_n = 5'h3;
        run(4'hA, 6'h00, 0, 0, 20400, 4'hF);
        run(4'hA, 6'h00, 3'h2, 0, 29000, 4'hF);
        repeat (4) begin
            m = 3'($urandom_range(7, 1));
            run(4'h0, {m, 3'h0}, 0, 0, itm_pkg::ADR_NS[m] + 1600, itm_pkg::SRC_CYC[m] + 1);
        end
        // previous space refused without memory management
        iclass = 4'h5;
        start = 1;
        @(negedge sys_clk) start = 0;
        `CHK("illegal", 1'b1, illegal_ff)
        // halt loop left by the console switch
        run(4'h8, 6'h00, itm_pkg::CT_HALT, 0, 2420, 1);
        `CHK("console", 1'b1, console_ff)
        console_pin = 1;
        repeat (70) @(negedge sys_clk);
        `CHK("console exit", 1'b0, console_ff)
        console_pin = 0;
        // wait loop holds until an interrupt
        run(4'h8, 6'h00, itm_pkg::CT_WAIT, 0, 2240, 1);
        repeat (300) @(negedge sys_clk);
        `CHK("wait busy", 1'b1, busy_ff)
        irq_pin = 1;
        serve(1'b0);
        // higher interrupt aborts a long float divide
        irq_higher = 1;
        iclass = 4'hA;
        sub_op = {1'b0, itm_pkg::FP_QUOT};
        start = 1;
        @(negedge sys_clk) start = 0;
        repeat (100) @(negedge sys_clk);
        irq_pin = 1;
        serve(1'b1);
        dma_go = 1;
        for (int k = 0; k < 600 && dma_grant_ff !== 1'b1; k++) @(negedge sys_clk);
        `CHK("dma latency", 1'b1, lat <= itm_pkg::DMA_CYC + 3)
        dma_go = 0;
        give_verdict;
    end
endmodule : itm_timer_bench
